// ### verilog/erf_defs.vh
`ifndef ERF_DEFS_VH
`define ERF_DEFS_VH

// register indexes; byte address is four times the index
`define ERF_IDX_PAYLOAD_SKIP 6'h03
`define ERF_IDX_FILTER_CTRL  6'h0c
`define ERF_IDX_LEN_FILTER   6'h0d
`define ERF_IDX_TOTAL_PKTS   6'h0e
`define ERF_IDX_CRC_ERRS     6'h0f
`define ERF_IDX_SRC_BASE     6'h12
`define ERF_IDX_SRC_LAST     6'h31

// filter control fields and reset value
`define ERF_CTRL_RAW_BIT     0
`define ERF_CTRL_CRCDIS_BIT  2
`define ERF_CTRL_PROMISC_BIT 4
`define ERF_CTRL_MASK        32'h00000015
`define ERF_CTRL_RESET       32'h00000010

// expected length register fields
`define ERF_LEN_EN_BIT       31
`define ERF_LEN_MASK         32'h8000ffff

// source compare entries
`define ERF_NUM_SRC          16
`define ERF_SRC_EN_BIT       31
`define ERF_SRC_HI_MASK      32'h8000ffff

// frame layout as delivered by the mac (preamble already stripped)
`define ERF_HDR_BYTES        32'h0000000e
`define ERF_FCS_BYTES        32'h00000004
`define ERF_OVERHEAD_BYTES   16'h0012
`define ERF_SRC_FIRST        14'h0006
`define ERF_SRC_LAST         14'h000b
`define ERF_PAD_MASK         32'h00000007

// frame store
`define ERF_BUF_AW           14
`define ERF_BUF_DEPTH        16384

`endif

// ### verilog/erf_rx_filter.v
`include "erf_defs.vh"
`default_nettype none

module erf_rx_filter (
  input  wire        clock,
  input  wire        rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        rx_valid,
  input  wire [7:0]  rx_data,
  input  wire        rx_last,
  input  wire        rx_crc_err,
  output reg         out_valid,
  output reg  [7:0]  out_data,
  output reg         out_last,
  input  wire        out_ready
);

  // overview of the receive filter
  //
  // the mac hands over one byte a cycle, starting at the destination
  // address (the preamble is already gone) and ending with the four
  // fcs bytes; rx_last marks the final fcs byte and rx_crc_err rides
  // with it when the mac found the frame check sequence wrong.
  //
  // each byte that arrives while collecting and fits goes into the single frame store while the source
  // address bytes (frame bytes six to eleven) are shifted into a
  // capture register. at the last byte the whole decision is made in
  // one cycle: crc, expected length and source address, each only
  // when its check is enabled, or none at all in raw mode.
  //
  // an accepted frame switches the engine to drain, which walks the
  // store from the first recorded byte to the end of the data, fcs
  // left out, with zero fill up to a whole eight byte word in raw
  // mode. the recorder side is a plain valid and ready handshake and
  // may stall on any cycle; the held byte never changes meanwhile.
  //
  // limitations a user must know:
  // - only one store exists, so frames that arrive while a previous
  //   frame drains are counted but not recorded; the mac side has no
  //   back-pressure to hold them off
  // - frames longer than the store are always rejected, in raw mode
  //   as well, since their tail would be lost anyway
  // - the payload skip is not checked against the frame length; a
  //   skip past the data end simply records nothing
  // - software must keep the recorded span a multiple of eight bytes
  //   outside raw mode; the block does not pad there
  //
  // counters:
  // - the total counter sees every frame end, in any mode and in any
  //   engine state, rejected or not
  // - the crc error counter sees every frame end flagged bad, even
  //   with crc checking disabled, so the error rate stays visible
  // - both clear on a write of zero; a frame end in the same cycle is
  //   still added, so the tally never loses a packet
  // - both wrap at all ones rather than sticking
  //
  // register bus:
  // - one wait state; pready is a registered one-cycle pulse
  // - read data is captured at the first access cycle and stands
  //   until the next read
  // - writes land only at the edge that completes the transfer
  // - an unmapped index answers with pslverr, reads zero and ignores
  //   writes

  // states of the frame engine
  localparam ST_RECV  = 1'b0;               // collecting a frame
  localparam ST_DRAIN = 1'b1;               // sending accepted bytes

  // software visible registers
  reg  [31:0] ctrl_r;                       // filter control
  reg  [31:0] len_r;                        // expected length filter
  reg  [31:0] skip_r;                       // payload skip offset
  reg  [31:0] total_r;                      // total packets
  reg  [31:0] crcerr_r;                     // crc error packets
  reg  [31:0] src_lo_r [0:`ERF_NUM_SRC-1];  // low four address bytes
  reg  [31:0] src_hi_r [0:`ERF_NUM_SRC-1];  // upper two bytes, enable

  // frame store and engine state
  reg  [7:0]  mem [0:`ERF_BUF_DEPTH-1];     // one whole frame
  reg         state_r;                      // engine state
  reg  [`ERF_BUF_AW-1:0] wr_cnt_r;          // bytes stored so far
  reg         full_r;                       // frame outgrew the store
  reg  [47:0] src_r;                        // captured source address
  reg  [31:0] rd_r;                         // next byte to send
  reg  [31:0] data_end_r;                   // first byte not from frame
  reg  [31:0] stop_r;                       // end including padding

  // bus decode
  wire [5:0]  idx     = paddr[7:2];         // register index
  wire        setup   = psel & penable & ~pready;
  wire        acc_wr  = psel & penable & pready & pwrite;
  wire        src_hit = (idx >= `ERF_IDX_SRC_BASE) &&
                        (idx <= `ERF_IDX_SRC_LAST);
  wire [5:0]  src_off = idx - `ERF_IDX_SRC_BASE;
  wire [3:0]  src_ent = src_off[4:1];       // compare entry number
  wire        src_up  = src_off[0];         // odd index is high word
  wire        mapped  = src_hit ||
                        (idx == `ERF_IDX_PAYLOAD_SKIP) ||
                        (idx == `ERF_IDX_FILTER_CTRL) ||
                        (idx == `ERF_IDX_LEN_FILTER) ||
                        (idx == `ERF_IDX_TOTAL_PKTS) ||
                        (idx == `ERF_IDX_CRC_ERRS);

  // mode bits
  wire raw_mode = ctrl_r[`ERF_CTRL_RAW_BIT];
  wire crc_dis  = ctrl_r[`ERF_CTRL_CRCDIS_BIT];
  wire promisc  = ctrl_r[`ERF_CTRL_PROMISC_BIT];
  wire len_en   = len_r[`ERF_LEN_EN_BIT];

  // frame end event and its full length including fcs
  wire        pkt_end = rx_valid & rx_last;
  wire [`ERF_BUF_AW-1:0] flen = wr_cnt_r + 1'b1;
  wire [15:0] flen16  = {2'b00, flen};

  // source address compare against every enabled entry
  reg         src_match;
  integer     k;
  always @* begin
    src_match = 1'b0;
    for (k = 0; k < `ERF_NUM_SRC; k = k + 1) begin
      if (src_hi_r[k][`ERF_SRC_EN_BIT] &&
          (src_r == {src_hi_r[k][15:0], src_lo_r[k]})) begin
        src_match = 1'b1;
      end
    end
  end

  // acceptance and the byte window to send, worked out at frame end
  reg         accept;
  reg         len_ok;
  reg  [31:0] start_b;
  reg  [31:0] end_b;
  reg  [31:0] span;
  reg  [31:0] stop_b;
  always @* begin
    len_ok  = (flen16 >= `ERF_OVERHEAD_BYTES) &&
              ((flen16 - `ERF_OVERHEAD_BYTES) == len_r[15:0]);
    if (raw_mode) begin
      accept = ~full_r;
    end else begin
      // every enabled check must pass
      accept = ~full_r &
               (crc_dis | ~rx_crc_err) &
               (~len_en | len_ok) &
               (promisc | src_match);
    end
    // skip counts from client data, or from frame start in raw mode
    if (raw_mode) begin
      start_b = skip_r;
    end else begin
      start_b = `ERF_HDR_BYTES + skip_r;
    end
    // fcs never leaves the block
    if ({18'h00000, flen} > `ERF_FCS_BYTES) begin
      end_b = {18'h00000, flen} - `ERF_FCS_BYTES;
    end else begin
      end_b = 32'h00000000;
    end
    if (end_b > start_b) begin
      span = end_b - start_b;
    end else begin
      span = 32'h00000000;
    end
    // raw captures are rounded up to whole eight byte words
    if (raw_mode) begin
      stop_b = start_b + ((span + `ERF_PAD_MASK) & ~`ERF_PAD_MASK);
    end else begin
      stop_b = start_b + span;              // software keeps it aligned
    end
  end

  // read data selection
  reg  [31:0] rd_mux;
  always @* begin
    if (idx == `ERF_IDX_PAYLOAD_SKIP) begin
      rd_mux = skip_r;
    end else if (idx == `ERF_IDX_FILTER_CTRL) begin
      rd_mux = ctrl_r;
    end else if (idx == `ERF_IDX_LEN_FILTER) begin
      rd_mux = len_r;
    end else if (idx == `ERF_IDX_TOTAL_PKTS) begin
      rd_mux = total_r;
    end else if (idx == `ERF_IDX_CRC_ERRS) begin
      rd_mux = crcerr_r;
    end else if (src_hit && src_up) begin
      rd_mux = src_hi_r[src_ent];
    end else if (src_hit) begin
      rd_mux = src_lo_r[src_ent];
    end else begin
      rd_mux = 32'h00000000;                // unmapped reads as zero
    end
  end

  // apb slave: one wait state, answer registered
  always @(posedge clock) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~mapped;           // unmapped address errors
      if (setup && !pwrite) begin
        prdata <= rd_mux;
      end
    end
  end

  // configuration registers, written at the completing edge only
  integer i;
  always @(posedge clock) begin
    if (rst) begin
      ctrl_r <= `ERF_CTRL_RESET;            // promiscuous after reset
      len_r  <= 32'h00000000;
      skip_r <= 32'h00000000;
      for (i = 0; i < `ERF_NUM_SRC; i = i + 1) begin
        src_lo_r[i] <= 32'h00000000;
        src_hi_r[i] <= 32'h00000000;
      end
    end else if (acc_wr) begin
      if (idx == `ERF_IDX_PAYLOAD_SKIP) begin
        skip_r <= pwdata;
      end else if (idx == `ERF_IDX_FILTER_CTRL) begin
        ctrl_r <= pwdata & `ERF_CTRL_MASK;
      end else if (idx == `ERF_IDX_LEN_FILTER) begin
        len_r <= pwdata & `ERF_LEN_MASK;
      end else if (src_hit && src_up) begin
        src_hi_r[src_ent] <= pwdata & `ERF_SRC_HI_MASK;
      end else if (src_hit) begin
        src_lo_r[src_ent] <= pwdata;
      end
    end
  end

  // counters: a zero write clears, a frame end in the same cycle
  // still counts so no packet is ever lost from the tally
  wire clr_total = acc_wr && (idx == `ERF_IDX_TOTAL_PKTS) &&
                   (pwdata == 32'h00000000);
  wire clr_crc   = acc_wr && (idx == `ERF_IDX_CRC_ERRS) &&
                   (pwdata == 32'h00000000);
  wire [31:0] total_base = clr_total ? 32'h00000000 : total_r;
  wire [31:0] crc_base   = clr_crc ? 32'h00000000 : crcerr_r;
  always @(posedge clock) begin
    if (rst) begin
      total_r  <= 32'h00000000;
      crcerr_r <= 32'h00000000;
    end else begin
      // every frame, in any mode and any state; wraps
      total_r  <= total_base + {31'h00000000, pkt_end};
      // counts regardless of the disable bit
      crcerr_r <= crc_base + {31'h00000000, pkt_end & rx_crc_err};
    end
  end

  // frame store write port, no reset needed on the array
  always @(posedge clock) begin
    if (state_r == ST_RECV && rx_valid && !full_r) begin
      mem[wr_cnt_r] <= rx_data;
    end
  end

  // frame engine: collect, decide at the last byte, then drain.
  // a single store keeps area down; frames that arrive while the
  // previous one is still draining are counted but not recorded.
  always @(posedge clock) begin
    if (rst) begin
      state_r    <= ST_RECV;
      wr_cnt_r   <= {`ERF_BUF_AW{1'b0}};
      full_r     <= 1'b0;
      src_r      <= 48'h000000000000;
      rd_r       <= 32'h00000000;
      data_end_r <= 32'h00000000;
      stop_r     <= 32'h00000000;
      out_valid  <= 1'b0;
      out_data   <= 8'h00;
      out_last   <= 1'b0;
    end else begin
      case (state_r)
        ST_RECV: begin
          if (rx_valid) begin
            // shift in the six source address bytes
            if (wr_cnt_r >= `ERF_SRC_FIRST &&
                wr_cnt_r <= `ERF_SRC_LAST) begin
              src_r <= {src_r[39:0], rx_data};
            end
            if (rx_last) begin
              wr_cnt_r <= {`ERF_BUF_AW{1'b0}};
              full_r   <= 1'b0;
              if (accept) begin
                state_r    <= ST_DRAIN;
                rd_r       <= start_b;
                data_end_r <= end_b;
                stop_r     <= stop_b;
              end
            end else if (&wr_cnt_r) begin
              full_r <= 1'b1;               // oversize frame is rejected
            end else begin
              wr_cnt_r <= wr_cnt_r + 1'b1;
            end
          end
        end
        ST_DRAIN: begin
          if (!out_valid || out_ready) begin
            if (rd_r < stop_r) begin
              out_valid <= 1'b1;
              // bytes past the frame are zero padding
              if (rd_r < data_end_r) begin
                out_data <= mem[rd_r[`ERF_BUF_AW-1:0]];
              end else begin
                out_data <= 8'h00;
              end
              out_last <= (rd_r + 32'h00000001) == stop_r;
              rd_r     <= rd_r + 32'h00000001;
            end else begin
              out_valid <= 1'b0;
              out_last  <= 1'b0;
              state_r   <= ST_RECV;
            end
          end
        end
        default: begin
          state_r <= ST_RECV;
        end
      endcase
    end
  end

endmodule // erf_rx_filter

`default_nettype wire

// ### bench/erf_chk.sv
`default_nettype none
module erf_chk (
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       rx_valid,
  input wire logic       rx_last,
  input wire logic       out_valid,
  input wire logic [7:0] out_data,
  input wire logic       out_last,
  input wire logic       out_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // first access-phase cycle, before the slave answers
  sequence s_access;
    psel && penable && !pready;
  endsequence
  // recorder byte offered and taken
  sequence s_taken;
    out_valid && out_ready;
  endsequence
  a_ready_late: assert property (s_access |=> pready)
    else $error("ready missing after access phase");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_ready_cause: assert property ($rose(pready) |-> $past(psel && penable))
    else $error("ready without access");
  a_out_hold: assert property (out_valid && !out_ready |=>
    out_valid && $stable(out_data) && $stable(out_last))
    else $error("recorder byte changed while stalled");
  a_gap_after_last: assert property (s_taken ##0 out_last |=> !out_valid)
    else $error("no gap after last byte");
  a_start_cause: assert property ($rose(out_valid) |->
    $past(rx_valid && rx_last) || $past(rx_valid && rx_last, 2))
    else $error("output without a finished frame");
  a_rst_quiet: assert property (disable iff (1'b0)
    rst |=> !pready && !out_valid)
    else $error("outputs active after reset");
endmodule // erf_chk
bind erf_rx_filter erf_chk u_chk (.clock, .rst, .psel, .penable, .pready,
  .pslverr, .rx_valid, .rx_last, .out_valid, .out_data, .out_last,
  .out_ready);
`default_nettype wire

// ### bench/erf_mac_model.sv
`default_nettype none
module erf_mac_model (
  input  wire logic       clock,
  output var  logic       rx_valid,
  output var  logic [7:0] rx_data,
  output var  logic       rx_last,
  output var  logic       rx_crc_err
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] frame [0:63]; // next frame in wire order, fcs at the end
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h5a;
    rx_last = 1'b0;
    rx_crc_err = 1'b0;
  end
  // one byte a cycle; the mac has no back-pressure to wait on
  task automatic send(input int n, input bit bad);
    for (int i = 0; i < n; i++) begin
      @(posedge clock);
      rx_valid <= 1'b1;
      rx_data <= frame[i];
      rx_last <= (i == n - 1);
      rx_crc_err <= bad && (i == n - 1);
    end
    @(posedge clock);
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    rx_crc_err <= 1'b0;
    rx_data <= ~rx_data; // idle byte lane must not look like a stale byte
  endtask
endmodule // erf_mac_model
`default_nettype wire

// ### bench/erf_rx_filter_tb.sv
`include "erf_defs.vh"
`default_nettype none
module erf_rx_filter_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e;
  logic [7:0]  paddr = 8'h00, rx_data, out_data;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic        pready, pslverr, rx_valid, rx_last, rx_crc_err;
  logic        out_valid, out_last, out_ready = 1'b1, stall = 1'b0;
  logic [7:0]  got [$]; // bytes taken by the recorder
  int          n_last = 0; // count of bytes taken up to the last marker
  int          n_errors = 0, samples_checked = 0;
  always #5 clock = ~clock;
  erf_rx_filter uut (.clock, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .rx_valid, .rx_data, .rx_last,
    .rx_crc_err, .out_valid, .out_data, .out_last, .out_ready);
  erf_mac_model mac (.clock, .rx_valid, .rx_data, .rx_last, .rx_crc_err);
  // recorder: take bytes, and stall every other cycle when asked
  always @(posedge clock) begin
    if (out_valid && out_ready) begin
      got.push_back(out_data);
      if (out_last)
        n_last = got.size();
    end
    out_ready <= stall ? ~out_ready : 1'b1;
  end
  task automatic chk(input logic [31:0] a, input logic [31:0] x);
    samples_checked++;
    if (a !== x) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, a, x);
    end
  endtask
  // one apb transfer, held until ready is sampled high
  task automatic apb(input logic w, input logic [5:0] i, input logic [31:0] d);
    int t = 0;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1 && ++t < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (t >= 50) n_errors++;
  endtask
  task automatic rd(input logic [5:0] i, input logic [31:0] x, input logic xe);
    apb(1'b0, i, 32'h0);
    chk(q, x);
    chk({31'h0, e}, {31'h0, xe});
  endtask
  task automatic wr(input logic [5:0] i, input logic [31:0] d);
    apb(1'b1, i, d);
  endtask
  // send a frame; expect frame[s..f-1] then zero fill, p bytes in all
  task automatic run(input int n, bit bad, int s, int f, int p);
    int k = 0;
    got.delete();
    n_last = 0;
    mac.send(n, bad);
    repeat (3) @(posedge clock);
    while (k < 200 && !(got.size() == p && !out_valid)) begin
      @(posedge clock);
      k++;
    end
    repeat (2) @(posedge clock);
    chk(got.size(), p);
    chk(n_last, p);
    for (int i = 0; i < p; i++)
      chk(got[i], (i < f - s) ? mac.frame[s + i] : 8'h00);
    $display("test done: frame of %0d bytes, %0d recorded", n, p);
  endtask
  task results();
    $display("checks %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // watchdog, well beyond the few hundred cycles the tests need
  initial begin
    #300000;
    n_errors++;
    results();
  end
  initial begin
    for (int i = 0; i < 64; i++)
      mac.frame[i] = 8'(i * 29 + 5);
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    stall <= 1'b1;
    rd(`ERF_IDX_FILTER_CTRL, 32'h10, 1'b0);
    rd(`ERF_IDX_TOTAL_PKTS, 32'h0, 1'b0);
    rd(6'h00, 32'h0, 1'b1);
    wr(`ERF_IDX_FILTER_CTRL, 32'hffffffff);
    rd(`ERF_IDX_FILTER_CTRL, 32'h15, 1'b0);
    wr(`ERF_IDX_FILTER_CTRL, 32'h10);
    wr(`ERF_IDX_PAYLOAD_SKIP, 32'h2);
    run(28, 0, 16, 24, 8);
    run(28, 1, 16, 24, 0);
    rd(`ERF_IDX_CRC_ERRS, 32'h1, 1'b0);
    wr(`ERF_IDX_FILTER_CTRL, 32'h14);
    run(28, 1, 16, 24, 8);
    rd(`ERF_IDX_CRC_ERRS, 32'h2, 1'b0);
    rd(`ERF_IDX_TOTAL_PKTS, 32'h3, 1'b0);
    wr(`ERF_IDX_CRC_ERRS, 32'h5);
    rd(`ERF_IDX_CRC_ERRS, 32'h2, 1'b0);
    wr(`ERF_IDX_CRC_ERRS, 32'h0);
    rd(`ERF_IDX_CRC_ERRS, 32'h0, 1'b0);
    wr(`ERF_IDX_TOTAL_PKTS, 32'h0);
    rd(`ERF_IDX_TOTAL_PKTS, 32'h0, 1'b0);
    wr(`ERF_IDX_FILTER_CTRL, 32'h0);
    run(28, 0, 16, 24, 0);
    wr(6'h19, {16'h8000, mac.frame[6], mac.frame[7]});
    wr(6'h18, {mac.frame[8], mac.frame[9], mac.frame[10], mac.frame[11]});
    run(28, 0, 16, 24, 8);
    wr(`ERF_IDX_LEN_FILTER, 32'h8000000a);
    run(28, 0, 16, 24, 8);
    wr(`ERF_IDX_LEN_FILTER, 32'h8000000b);
    run(28, 0, 16, 24, 0);
    wr(6'h19, {16'h0000, mac.frame[6], mac.frame[7]});
    wr(`ERF_IDX_PAYLOAD_SKIP, 32'h1);
    wr(`ERF_IDX_FILTER_CTRL, 32'h1);
    run(17, 1, 1, 13, 16);
    rd(`ERF_IDX_TOTAL_PKTS, 32'h5, 1'b0);
    results();
  end
endmodule // erf_rx_filter_tb
`default_nettype wire
